//--- common/snsd_consts.svh
// constants for the serial node switch decoder
`ifndef SNSD_CONSTS_SVH
`define SNSD_CONSTS_SVH

// ----------------------------------------------------------------
// switch bank layout (switch n sits at bit n-1)
// ----------------------------------------------------------------
`define SNSD_SW_WIDTH 8
`define SNSD_ADDR_LSB 0
`define SNSD_ADDR_MSB 5
`define SNSD_RATE_LSB 6
`define SNSD_RATE_MSB 7

// ----------------------------------------------------------------
// field codes
// ----------------------------------------------------------------
`define SNSD_ADDR_FROM_NVM 6'h00
`define SNSD_RATE_FROM_NVM 2'h0
`define SNSD_RATE_9K6 2'h1
`define SNSD_RATE_38K4 2'h2
`define SNSD_RATE_115K2 2'h3

// ----------------------------------------------------------------
// bit rates and clock-cycle divisors, rounded to nearest
// ----------------------------------------------------------------
`define SNSD_CLK_HZ 250000000
`define SNSD_BAUD_9K6 9600
`define SNSD_BAUD_38K4 38400
`define SNSD_BAUD_115K2 115200
`define SNSD_DIV_9K6 16'((`SNSD_CLK_HZ + (`SNSD_BAUD_9K6 / 2)) / `SNSD_BAUD_9K6)
`define SNSD_DIV_38K4 16'((`SNSD_CLK_HZ + (`SNSD_BAUD_38K4 / 2)) / `SNSD_BAUD_38K4)
`define SNSD_DIV_115K2 16'((`SNSD_CLK_HZ + (`SNSD_BAUD_115K2 / 2)) / `SNSD_BAUD_115K2)

// ----------------------------------------------------------------
// reset values and settle time after reset (synchroniser fill)
// ----------------------------------------------------------------
`define SNSD_ADDR_RST 6'h00
`define SNSD_DIV_RST 16'h0000
`define SNSD_SETTLE_CYC 3'h4
`define SNSD_CNT_RST 3'h0
`define SNSD_CNT_STEP 3'h1

`endif

//--- common/snsd_pkg.sv
// types for the serial node switch decoder
package snsd_pkg;

  typedef logic [5:0] snsd_addr_t;
  typedef logic [1:0] snsd_rate_t;
  typedef logic [15:0] snsd_div_t;
  typedef logic [7:0] snsd_sw_t;

  typedef enum logic [2:0] {
    SNSD_ST_WAIT = 3'b001,
    SNSD_ST_LATCH = 3'b010,
    SNSD_ST_DONE = 3'b100
  } snsd_state_e;

endpackage

//--- core/snsd_sync.sv
// two-flop synchroniser bank for the configuration switches
`timescale 1ns/1ps
module snsd_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // raw and synchronised levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // ----------------------------------------------------------------
  // one two-stage chain per switch
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_reg;

endmodule // snsd_sync

//--- core/snsd_decode.sv
// switch bank decoder for multidrop serial node address and bit rate
// ----------------------------------------------------------------
// Notes on behaviour
// RQ1: switches one to six form the node address, switch one lsb, on is one.
// RQ2: switches seven and eight form the rate code, switch seven lsb.
// RQ3: switch values steer only the multidrop port; point-to-point untouched.
// RQ4: an all-zero switch address selects the stored node address.
// RQ5: a zero rate code selects the stored bit rate.
// RQ6: codes one, two, three select 9.6, 38.4 and 115.2 kbit/s.
// RQ7: switches sampled after reset and held until the next reset.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "snsd_consts.svh"
module snsd_decode (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // switch bank, one bit per switch, on reads as one
  input wire snsd_pkg::snsd_sw_t sw_on_in,
  // non-volatile parameter store
  input wire logic nvm_valid_in,
  input wire snsd_pkg::snsd_addr_t nvm_addr_in,
  input wire snsd_pkg::snsd_div_t nvm_baud_div_in,
  // serial port mode and point-to-point setting
  input wire logic mode_multidrop_in,
  input wire snsd_pkg::snsd_div_t p2p_baud_div_in,
  // decoded multidrop configuration
  output snsd_pkg::snsd_addr_t md_addr_out,
  output snsd_pkg::snsd_div_t md_baud_div_out,
  output snsd_pkg::snsd_rate_t md_rate_code_out,
  output logic addr_from_nvm_out,
  output logic rate_from_nvm_out,
  output logic cfg_valid_out,
  // divisor for whichever port mode is active
  output snsd_pkg::snsd_div_t port_baud_div_out
);
  import snsd_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  snsd_sw_t sw_sync;
  snsd_state_e state_reg;
  snsd_state_e state_next;
  logic [2:0] settle_cnt_reg;
  logic [2:0] settle_cnt_next;
  snsd_addr_t md_addr_reg;
  snsd_div_t md_div_reg;
  snsd_rate_t md_rate_reg;
  logic addr_nvm_reg;
  logic rate_nvm_reg;
  snsd_div_t port_div_reg;

  // ----------------------------------------------------------------
  // switch synchroniser
  // ----------------------------------------------------------------
  snsd_sync #(
    .WIDTH(`SNSD_SW_WIDTH)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(sw_on_in),
    .sync_out(sw_sync)
  );

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire snsd_addr_t sw_addr = sw_sync[`SNSD_ADDR_MSB:`SNSD_ADDR_LSB]; // [RQ1]
  wire snsd_rate_t sw_rate = sw_sync[`SNSD_RATE_MSB:`SNSD_RATE_LSB]; // [RQ2]
  wire addr_use_nvm = (sw_addr == `SNSD_ADDR_FROM_NVM); // [RQ4]
  wire rate_use_nvm = (sw_rate == `SNSD_RATE_FROM_NVM); // [RQ5]
  wire snsd_addr_t addr_sel = addr_use_nvm ? nvm_addr_in : sw_addr; // [RQ4]
  wire snsd_div_t table_div =
    (sw_rate == `SNSD_RATE_9K6) ? `SNSD_DIV_9K6 :
    (sw_rate == `SNSD_RATE_38K4) ? `SNSD_DIV_38K4 :
    `SNSD_DIV_115K2; // [RQ6]
  wire snsd_div_t div_sel = rate_use_nvm ? nvm_baud_div_in : table_div; // [RQ5]
  wire settle_done = (settle_cnt_reg == `SNSD_SETTLE_CYC);
  wire do_latch = (state_reg == SNSD_ST_LATCH);
  wire cfg_valid = (state_reg == SNSD_ST_DONE);
  // switches reach only the multidrop divisor
  wire snsd_div_t port_div_sel = mode_multidrop_in ? md_div_reg : p2p_baud_div_in; // [RQ3]

  // ----------------------------------------------------------------
  // capture sequence: settle, wait for store, latch once
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SNSD_ST_WAIT: begin
        if (settle_done && nvm_valid_in) begin
          state_next = SNSD_ST_LATCH;
        end
      end
      SNSD_ST_LATCH: begin
        state_next = SNSD_ST_DONE;
      end
      SNSD_ST_DONE: begin
        state_next = SNSD_ST_DONE; // [RQ7]
      end
      default: begin
        state_next = SNSD_ST_WAIT;
      end
    endcase
  end

  assign settle_cnt_next = settle_done ? settle_cnt_reg : 3'(settle_cnt_reg + `SNSD_CNT_STEP);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state_reg <= SNSD_ST_WAIT;
      settle_cnt_reg <= `SNSD_CNT_RST;
    end else begin
      state_reg <= state_next;
      settle_cnt_reg <= settle_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // latched configuration
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      md_addr_reg <= `SNSD_ADDR_RST;
      md_div_reg <= `SNSD_DIV_RST;
      md_rate_reg <= `SNSD_RATE_FROM_NVM;
      addr_nvm_reg <= 1'b0;
      rate_nvm_reg <= 1'b0;
    end else if (do_latch) begin
      md_addr_reg <= addr_sel; // [RQ7]
      md_div_reg <= div_sel; // [RQ7]
      md_rate_reg <= sw_rate;
      addr_nvm_reg <= addr_use_nvm;
      rate_nvm_reg <= rate_use_nvm;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      port_div_reg <= `SNSD_DIV_RST;
    end else begin
      port_div_reg <= port_div_sel; // [RQ3]
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign md_addr_out = md_addr_reg;
  assign md_baud_div_out = md_div_reg;
  assign md_rate_code_out = md_rate_reg;
  assign addr_from_nvm_out = addr_nvm_reg;
  assign rate_from_nvm_out = rate_nvm_reg;
  assign cfg_valid_out = cfg_valid;
  assign port_baud_div_out = port_div_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  addr_switch_map_a: assert property ( // [RQ1]
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (do_latch && !addr_use_nvm) |=>
      (md_addr_out == $past(sw_sync[`SNSD_ADDR_MSB:`SNSD_ADDR_LSB])) && !addr_from_nvm_out &&
      cfg_valid_out
  ) else $error("switch address not latched");

  rate_switch_map_a: assert property ( // [RQ2]
    @(posedge core_clk_in) disable iff (!reset_n_in)
    do_latch |=> (md_rate_code_out ==
      {$past(sw_sync[`SNSD_RATE_MSB]), $past(sw_sync[`SNSD_RATE_LSB])})
  ) else $error("rate code bits misordered");

  p2p_untouched_a: assert property ( // [RQ3]
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (!mode_multidrop_in ##1 1'b1) |-> (port_baud_div_out == $past(p2p_baud_div_in))
  ) else $error("point-to-point divisor altered");

  addr_nvm_fallback_a: assert property ( // [RQ4]
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (do_latch && sw_sync[`SNSD_ADDR_MSB:`SNSD_ADDR_LSB] == `SNSD_ADDR_FROM_NVM) |=>
      (md_addr_out == $past(nvm_addr_in)) && addr_from_nvm_out
  ) else $error("stored address not used");

  rate_nvm_fallback_a: assert property ( // [RQ5]
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (do_latch && sw_sync[`SNSD_RATE_MSB:`SNSD_RATE_LSB] == `SNSD_RATE_FROM_NVM) |=>
      (md_baud_div_out == $past(nvm_baud_div_in)) && rate_from_nvm_out
  ) else $error("stored bit rate not used");

  rate_table_a: assert property ( // [RQ6]
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (do_latch && sw_sync[`SNSD_RATE_MSB:`SNSD_RATE_LSB] != `SNSD_RATE_FROM_NVM) |=>
      (md_baud_div_out == (($past(sw_rate) == `SNSD_RATE_9K6) ? `SNSD_DIV_9K6 :
                           ($past(sw_rate) == `SNSD_RATE_38K4) ? `SNSD_DIV_38K4 :
                           `SNSD_DIV_115K2))
  ) else $error("bit rate divisor wrong");

  config_hold_a: assert property ( // [RQ7]
    @(posedge core_clk_in) disable iff (!reset_n_in)
    cfg_valid_out |=> cfg_valid_out && $stable(md_addr_out) && $stable(md_baud_div_out)
  ) else $error("latched configuration changed");

  latch_timing_a: assert property ( // [RQ7]
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (!cfg_valid_out && !do_latch && settle_done && nvm_valid_in) |=>
      do_latch ##1 cfg_valid_out
  ) else $error("latch sequence late");

  // no latch before the synchroniser has settled
  settle_first_a: assert property ( // [RQ7]
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (!settle_done && !cfg_valid_out) |=> !do_latch && !cfg_valid_out
  ) else $error("latched before settle");

  store_wait_a: assert property ( // [RQ7]
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (!cfg_valid_out && !do_latch && !nvm_valid_in) |=> !do_latch && !cfg_valid_out
  ) else $error("latched without valid store");

  md_port_path_a: assert property ( // [RQ3]
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (mode_multidrop_in ##1 1'b1) |-> (port_baud_div_out == $past(md_baud_div_out))
  ) else $error("multidrop divisor not routed");

endmodule // snsd_decode

//--- tb/snsd_partner.sv
// switch bank and parameter store model for the decoder bench
`timescale 1ns/1ps
module snsd_partner (
  // switch bank
  output snsd_pkg::snsd_sw_t sw_on_out,
  // parameter store
  output logic nvm_valid_out,
  output snsd_pkg::snsd_addr_t nvm_addr_out,
  output snsd_pkg::snsd_div_t nvm_baud_div_out
);
  import snsd_pkg::*;
  initial begin
    sw_on_out = 8'h00;
    nvm_valid_out = 1'b0;
    nvm_addr_out = 6'h2a;
    nvm_baud_div_out = 16'h5555;
  end
  task automatic set_switches(input snsd_sw_t v);
    sw_on_out = v;
  endtask
  // store not ready: contents shown inverted, never the real value
  task automatic set_store(input logic v, input snsd_addr_t a, input snsd_div_t d);
    nvm_valid_out = v;
    nvm_addr_out = v ? a : ~a;
    nvm_baud_div_out = v ? d : ~d;
  endtask
endmodule // snsd_partner

//--- tb/serial_node_switch_decode_bench.sv
// self-checking bench for the switch bank decoder
`timescale 1ns/1ps
module serial_node_switch_decode_bench;
  import snsd_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic mode_multidrop_in = 1'b1;
  snsd_div_t p2p_baud_div_in = 16'h0abc;
  snsd_sw_t sw;
  logic nvm_valid;
  snsd_addr_t nvm_addr, md_addr;
  snsd_div_t nvm_div, md_div, port_div;
  snsd_rate_t md_code;
  logic addr_nvm, rate_nvm, cfg_valid;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2 core_clk_in = ~core_clk_in;
  snsd_partner u_part (.sw_on_out(sw), .nvm_valid_out(nvm_valid), .nvm_addr_out(nvm_addr),
    .nvm_baud_div_out(nvm_div));
  snsd_decode u_dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .sw_on_in(sw),
    .nvm_valid_in(nvm_valid), .nvm_addr_in(nvm_addr), .nvm_baud_div_in(nvm_div),
    .mode_multidrop_in(mode_multidrop_in), .p2p_baud_div_in(p2p_baud_div_in),
    .md_addr_out(md_addr), .md_baud_div_out(md_div), .md_rate_code_out(md_code),
    .addr_from_nvm_out(addr_nvm), .rate_from_nvm_out(rate_nvm), .cfg_valid_out(cfg_valid),
    .port_baud_div_out(port_div));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic restart(input snsd_sw_t s, input logic v);
    @(negedge core_clk_in);
    reset_n_in = 1'b0;
    u_part.set_switches(s);
    u_part.set_store(v, 6'h15, 16'h1234);
    repeat (3) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    @(negedge core_clk_in);
    check("valid_early", 16'h0, {15'h0, cfg_valid});
  endtask
  task automatic wait_cfg();
    int n;
    for (n = 0; n < 20 && cfg_valid !== 1'b1; n++) @(negedge core_clk_in);
    check("valid", 16'h1, {15'h0, cfg_valid});
  endtask
  task automatic expect_cfg(input snsd_addr_t a, input snsd_div_t d, input snsd_rate_t c,
      input logic an, input logic rn);
    check("addr", {10'h0, a}, {10'h0, md_addr});
    check("div", d, md_div);
    check("code", {14'h0, c}, {14'h0, md_code});
    check("addr_nvm", {15'h0, an}, {15'h0, addr_nvm});
    check("rate_nvm", {15'h0, rn}, {15'h0, rate_nvm});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_switch_fields();
    restart(8'h6b, 1'b1);
    wait_cfg();
    expect_cfg(6'h2b, 16'h65ba, 2'h1, 1'b0, 1'b0);
    restart(8'h81, 1'b1);
    wait_cfg();
    expect_cfg(6'h01, 16'h196e, 2'h2, 1'b0, 1'b0);
    restart(8'hff, 1'b1);
    wait_cfg();
    expect_cfg(6'h3f, 16'h087a, 2'h3, 1'b0, 1'b0);
  endtask
  task automatic t_store_fallback();
    restart(8'h00, 1'b1);
    wait_cfg();
    expect_cfg(6'h15, 16'h1234, 2'h0, 1'b1, 1'b1);
    restart(8'hc0, 1'b1);
    wait_cfg();
    expect_cfg(6'h15, 16'h087a, 2'h3, 1'b1, 1'b0);
    restart(8'h05, 1'b1);
    wait_cfg();
    expect_cfg(6'h05, 16'h1234, 2'h0, 1'b0, 1'b1);
  endtask
  task automatic t_hold_and_mode();
    restart(8'h6b, 1'b1);
    wait_cfg();
    u_part.set_switches(8'h80);
    u_part.set_store(1'b1, 6'h0f, 16'h0f0f);
    repeat (10) @(negedge core_clk_in);
    expect_cfg(6'h2b, 16'h65ba, 2'h1, 1'b0, 1'b0);
    check("port_md", 16'h65ba, port_div);
    mode_multidrop_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
    check("port_p2p", 16'h0abc, port_div);
    u_part.set_switches(8'h3c);
    p2p_baud_div_in = 16'h0123;
    repeat (2) @(negedge core_clk_in);
    check("port_p2p2", 16'h0123, port_div);
    mode_multidrop_in = 1'b1;
  endtask
  task automatic t_late_store();
    restart(8'h40, 1'b0);
    repeat (12) @(negedge core_clk_in);
    check("valid_wait", 16'h0, {15'h0, cfg_valid});
    u_part.set_store(1'b1, 6'h15, 16'h1234);
    wait_cfg();
    expect_cfg(6'h15, 16'h65ba, 2'h1, 1'b1, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic final_report();
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    t_switch_fields();
    t_store_fallback();
    t_hold_and_mode();
    t_late_store();
    final_report();
  end
endmodule // serial_node_switch_decode_bench
